// ### design/iasq_pkg.sv
// constants and state layout shared by the interrupt accept sequencer
`default_nettype none
package iasq_pkg;
   // ----------------------------------------------------------------
   // sources and widths
   // ----------------------------------------------------------------
   localparam int NSRC = 12;
   localparam int SRC_W = 4;
   localparam int PC_W = 14;
   localparam int SYS_W = 28;
   localparam int WIN_LSB = 0;
   localparam int WIN_W = 4;
   localparam int ASK_DEPTH = 8;
   localparam int SP_W = 3;
   localparam int ISK_LEVELS = 4;
   localparam int ISP_W = 3;
   // ----------------------------------------------------------------
   // reset values and codes
   // ----------------------------------------------------------------
   localparam logic [SP_W-1:0] SP_RST = 3'h0;
   localparam logic [ISP_W-1:0] ISP_EMPTY = 3'h5;
   localparam logic [ISP_W-1:0] ISP_FULL = 3'h1;
   localparam logic [PC_W-1:0] VEC_TOP = 14'h000c;
   localparam logic [SYS_W-1:0] WIN_MASK = 28'h000000f;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam real INSTR_TIME_US = 1.78;
   localparam real CLK_MHZ = 250.0;
   localparam int INSTR_CYC = $rtoi(INSTR_TIME_US * CLK_MHZ + 0.5);
   localparam int CYC_W = 9;
   localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(INSTR_CYC - 1);
   localparam logic [CYC_W-1:0] CYC_ZERO = 9'h000;
   // ----------------------------------------------------------------
   // whole state of the sequencer
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [CYC_W-1:0] div_cnt;
      logic instr_start;
      logic gate;
      logic ei_pend;
      logic in_irq_cycle;
      logic [NSRC-1:0] req_flag;
      logic [ASK_DEPTH-1:0][PC_W-1:0] return_address_stack;
      logic [SP_W-1:0] sp;
      logic [ISK_LEVELS-1:0][SYS_W-1:0] isk;
      logic [ISP_W-1:0] isp;
      logic [PC_W-1:0] pc_load;
      logic pc_load_valid;
      logic [SYS_W-1:0] sys_out;
      logic sys_restore_valid;
      logic sys_clear;
      logic [SRC_W-1:0] accepted_src;
   } iasq_state_s;
endpackage
`default_nettype wire

// ### design/iasq_vector_pick.sv
// fixed-priority source picker and vector generator
`default_nettype none
module iasq_vector_pick
   import iasq_pkg::*;
(
   // qualified requests, bit 0 highest priority
   input wire logic [NSRC-1:0] pending_i,
   // selection
   output logic any_o,
   output logic [SRC_W-1:0] src_o,
   output logic [PC_W-1:0] vector_o
);
   // ----------------------------------------------------------------
   // lowest set index wins
   // ----------------------------------------------------------------
   always_comb begin
      any_o = |pending_i;
      src_o = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (pending_i[i]) begin
            src_o = SRC_W'(i); // R9
         end
      end
      vector_o = VEC_TOP - PC_W'(src_o); // R16
   end
endmodule // iasq_vector_pick
`default_nettype wire

// ### design/iasq_sequencer.sv
// interrupt accept sequencer: gate, request flags, stacks and interrupt cycle
// ----------------------------------------------------------------
// Notes on behaviour
// R1 - on accept, decrement stack pointer then store pc at the new slot
// R2 - on return, load pc from slot at stack pointer, then increment pointer
// R3 - one global gate enables or blocks all twelve sources
// R4 - enable sets gate after the next instruction starts; disable clears it at once
// R5 - gate clears whenever an interrupt is accepted
// R6 - all resets clear the gate; clock stop keeps it
// R7 - a peripheral request pulse sets its request flag
// R8 - accept only when request flag, mask flag and gate are all one
// R9 - simultaneous requests are taken in fixed order, chip-enable edge first
// R10 - a source with mask flag zero is never accepted
// R11 - table-read first cycle or taken skip defers acceptance one instruction
// R12 - request set during enable waits until the following instruction completes
// R13 - accept clears gate and flag, pushes pc, saves system regs, loads vector
// R14 - pushed pc is the next address the core would execute
// R15 - acceptance takes exactly one instruction time with no normal instruction
// R16 - vectors run from 0x0c for chip-enable down to 0x01 for serial 1
// R17 - saving clears system registers except window; four nesting levels kept
// R18 - acceptance only at instruction boundaries, one source per interrupt cycle
// R19 - unaccepted flags stay set until accepted or cleared by software
// ----------------------------------------------------------------
`default_nettype none
module iasq_sequencer
   import iasq_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // other reset sources, synchronous to ref_clk_i
   input wire logic reset_pin_i,
   input wire logic wdt_reset_i,
   input wire logic stack_fault_i,
   input wire logic ce_reset_i,
   // peripheral requests and software flag control
   input wire logic [NSRC-1:0] req_i,
   input wire logic [NSRC-1:0] sw_clear_i,
   input wire logic [NSRC-1:0] mask_enable_i,
   // core instruction status
   input wire logic irq_enable_instr_i,
   input wire logic irq_disable_instr_i,
   input wire logic irq_return_instr_i,
   input wire logic defer_i,
   input wire logic [PC_W-1:0] next_pc_i,
   input wire logic [SYS_W-1:0] sys_regs_i,
   // timing to the core
   output logic instr_start_o,
   output logic irq_cycle_o,
   // status
   output logic global_irq_gate_o,
   output logic [NSRC-1:0] req_flag_o,
   output logic [SP_W-1:0] sp_o,
   output logic [ISP_W-1:0] isp_o,
   output logic [SRC_W-1:0] accepted_src_o,
   // program counter and system register updates
   output logic [PC_W-1:0] pc_load_o,
   output logic pc_load_valid_o,
   output logic [SYS_W-1:0] sys_out_o,
   output logic sys_restore_valid_o,
   output logic sys_clear_o
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   iasq_state_s s_reg;
   iasq_state_s s_next;
   logic [NSRC-1:0] pending;
   logic pick_any;
   logic [SRC_W-1:0] pick_src;
   logic [PC_W-1:0] pick_vec;
   logic boundary;
   logic accept;
   logic do_return;
   logic [SP_W-1:0] sp_dec;

   // ----------------------------------------------------------------
   // qualification and priority
   // ----------------------------------------------------------------
   assign pending = s_reg.req_flag & mask_enable_i; // R8 R10

   iasq_vector_pick u_pick (
      .pending_i(pending),
      .any_o(pick_any),
      .src_o(pick_src),
      .vector_o(pick_vec)
   );

   assign boundary = (s_reg.div_cnt == CYC_LAST); // R18
   // gate, flag and mask are all sampled at the boundary; deferral holds it off
   assign accept = boundary && !s_reg.in_irq_cycle && s_reg.gate && pick_any
                   && !defer_i; // R3 R8 R11 R12
   // a return pulse in the boundary cycle is not taken
   assign do_return = irq_return_instr_i && !boundary;
   assign sp_dec = s_reg.sp - SP_W'(1);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.pc_load_valid = 1'b0;
      s_next.sys_restore_valid = 1'b0;
      s_next.sys_clear = 1'b0;
      s_next.instr_start = boundary;

      // instruction time divider
      if (boundary) begin
         s_next.div_cnt = CYC_ZERO;
      end else begin
         s_next.div_cnt = s_reg.div_cnt + CYC_W'(1);
      end

      // interrupt cycle spans exactly one instruction time
      if (boundary) begin
         s_next.in_irq_cycle = accept; // R15
      end

      // enable arms the gate for the next instruction; disable acts now
      if (irq_enable_instr_i) begin
         s_next.ei_pend = 1'b1; // R4
      end
      if (boundary && s_reg.ei_pend) begin
         s_next.gate = 1'b1; // R4 R12
         s_next.ei_pend = 1'b0;
      end
      if (irq_disable_instr_i) begin
         s_next.gate = 1'b0; // R4
         s_next.ei_pend = 1'b0;
      end

      // request flags hold until accepted or cleared; a new request wins
      s_next.req_flag = s_reg.req_flag & ~sw_clear_i; // R19
      if (accept) begin
         s_next.req_flag[pick_src] = 1'b0; // R13
      end
      s_next.req_flag = s_next.req_flag | req_i; // R7

      // return: pop pc and system registers
      if (do_return) begin
         s_next.pc_load = s_reg.return_address_stack[s_reg.sp]; // R2
         s_next.pc_load_valid = 1'b1;
         s_next.sp = s_reg.sp + SP_W'(1); // R2
         s_next.sys_out = s_reg.isk[0];
         s_next.sys_restore_valid = 1'b1;
         for (int i = 0; i < ISK_LEVELS - 1; i++) begin
            s_next.isk[i] = s_reg.isk[i+1];
         end
         s_next.isk[ISK_LEVELS-1] = '0;
         if (s_reg.isp != ISP_EMPTY) begin
            s_next.isp = s_reg.isp + ISP_W'(1);
         end
      end

      // accept: one source, gate off, push, save, vector
      if (accept) begin
         s_next.gate = 1'b0; // R5 R13
         s_next.ei_pend = 1'b0;
         s_next.accepted_src = pick_src; // R18
         s_next.sp = sp_dec; // R1 R13
         s_next.return_address_stack[sp_dec] = next_pc_i; // R1 R14
         // oldest level falls off when a fifth level is pushed
         for (int i = ISK_LEVELS - 1; i > 0; i--) begin
            s_next.isk[i] = s_reg.isk[i-1]; // R17
         end
         s_next.isk[0] = sys_regs_i; // R13
         if (s_reg.isp != ISP_FULL) begin
            s_next.isp = s_reg.isp - ISP_W'(1); // R17
         end
         s_next.sys_out = sys_regs_i & WIN_MASK; // R17
         s_next.sys_clear = 1'b1; // R17
         s_next.pc_load = pick_vec; // R13 R16
         s_next.pc_load_valid = 1'b1;
      end

      // every other reset source clears the gate
      if (reset_pin_i || wdt_reset_i || stack_fault_i || ce_reset_i) begin
         s_next.gate = 1'b0; // R6
         s_next.ei_pend = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_reg <= '0;
         s_reg.gate <= 1'b0; // R6
         s_reg.sp <= SP_RST;
         s_reg.isp <= ISP_EMPTY;
         s_reg.div_cnt <= CYC_ZERO;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign instr_start_o = s_reg.instr_start;
   assign irq_cycle_o = s_reg.in_irq_cycle; // R15
   assign global_irq_gate_o = s_reg.gate;
   assign req_flag_o = s_reg.req_flag;
   assign sp_o = s_reg.sp;
   assign isp_o = s_reg.isp;
   assign accepted_src_o = s_reg.accepted_src;
   assign pc_load_o = s_reg.pc_load;
   assign pc_load_valid_o = s_reg.pc_load_valid;
   assign sys_out_o = s_reg.sys_out;
   assign sys_restore_valid_o = s_reg.sys_restore_valid;
   assign sys_clear_o = s_reg.sys_clear;
endmodule // iasq_sequencer
`default_nettype wire

// ### dv/iasq_sequencer_chk.sv
// port-level assertions for the interrupt accept sequencer
`default_nettype none
module iasq_sequencer_chk
   import iasq_pkg::*;
(
   // clock and resets
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic reset_pin_i,
   input wire logic wdt_reset_i,
   input wire logic stack_fault_i,
   input wire logic ce_reset_i,
   // watched inputs and outputs
   input wire logic [NSRC-1:0] mask_enable_i,
   input wire logic irq_disable_instr_i,
   input wire logic instr_start_o,
   input wire logic irq_cycle_o,
   input wire logic global_irq_gate_o,
   input wire logic [NSRC-1:0] req_flag_o,
   input wire logic [SP_W-1:0] sp_o,
   input wire logic [SRC_W-1:0] accepted_src_o,
   input wire logic [PC_W-1:0] pc_load_o,
   input wire logic pc_load_valid_o,
   input wire logic sys_restore_valid_o,
   input wire logic sys_clear_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [NSRC-1:0] qual_reg;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) qual_reg <= '0;
      else qual_reg <= req_flag_o & mask_enable_i;
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   AST_GATE_ACC: assert property ($rose(irq_cycle_o) |->
      !global_irq_gate_o && $past(global_irq_gate_o)) else $error("gate wrong at accept");
   AST_PULSES: assert property ($rose(irq_cycle_o) |->
      pc_load_valid_o && sys_clear_o && instr_start_o) else $error("accept pulses missing");
   AST_VECTOR: assert property ($rose(irq_cycle_o) |->
      pc_load_o == VEC_TOP - {10'h000, accepted_src_o}) else $error("wrong vector");
   AST_SP_DEC: assert property ($rose(irq_cycle_o) |->
      sp_o == $past(sp_o) - 3'h1) else $error("stack pointer not decremented");
   AST_PRIORITY: assert property ($rose(irq_cycle_o) |-> qual_reg[accepted_src_o] &&
      (qual_reg & ((12'h001 << accepted_src_o) - 12'h001)) == 12'h000) else $error("bad pick");
   AST_IRQ_LEN: assert property ($rose(irq_cycle_o) |->
      ##[445:445] (instr_start_o && !irq_cycle_o)) else $error("interrupt cycle length");
   AST_DISABLE: assert property (irq_disable_instr_i |=> !global_irq_gate_o)
      else $error("disable did not clear gate");
   AST_RESETS: assert property ((reset_pin_i || wdt_reset_i || stack_fault_i || ce_reset_i)
      |=> !global_irq_gate_o) else $error("reset did not clear gate");
   AST_RETURN: assert property ($rose(sys_restore_valid_o) |->
      pc_load_valid_o && sp_o == $past(sp_o) + 3'h1) else $error("return pop wrong");
endmodule // iasq_sequencer_chk
bind iasq_sequencer iasq_sequencer_chk u_chk (.ref_clk_i, .rst_i, .reset_pin_i, .wdt_reset_i,
   .stack_fault_i, .ce_reset_i, .mask_enable_i, .irq_disable_instr_i, .instr_start_o,
   .irq_cycle_o, .global_irq_gate_o, .req_flag_o, .sp_o, .accepted_src_o, .pc_load_o,
   .pc_load_valid_o, .sys_restore_valid_o, .sys_clear_o);
`default_nettype wire

// ### dv/iasq_core_model.sv
// behavioural core: program counter and system registers
`default_nettype none
module iasq_core_model
   import iasq_pkg::*;
(
   // clock, reset and sequencer status
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic step_i,
   input wire logic load_i,
   input wire logic [PC_W-1:0] load_pc_i,
   // core state
   output logic [PC_W-1:0] next_pc_o,
   output logic [SYS_W-1:0] sys_regs_o
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) next_pc_o <= 14'h0100;
      else if (load_i) next_pc_o <= load_pc_i;
      else if (step_i) next_pc_o <= next_pc_o + 14'h0001;
   end
   assign sys_regs_o = {next_pc_o, ~next_pc_o};
endmodule // iasq_core_model
`default_nettype wire

// ### dv/iasq_sequencer_test.sv
// self-checking bench for the interrupt accept sequencer
`default_nettype none
module iasq_sequencer_test
   import iasq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, ein, dis, ret, dfr, ist, irq, gate, plv, srv, sclr;
   logic [3:0] rs;
   logic [NSRC-1:0] rq, swc, msk, flg;
   logic [PC_W-1:0] npc, rpc, pcl;
   logic [SYS_W-1:0] sys, sout, rsys;
   logic [SP_W-1:0] sp;
   logic [ISP_W-1:0] isp;
   logic [SRC_W-1:0] acc;
   logic [SRC_W-1:0] order [3] = '{4'h2, 4'h1, 4'h5};
   int n_errors, checks_done;
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   iasq_sequencer DUT (.ref_clk_i(clk), .rst_i(rst), .reset_pin_i(rs[0]), .wdt_reset_i(rs[1]),
      .stack_fault_i(rs[2]), .ce_reset_i(rs[3]), .req_i(rq), .sw_clear_i(swc),
      .mask_enable_i(msk), .irq_enable_instr_i(ein), .irq_disable_instr_i(dis),
      .irq_return_instr_i(ret), .defer_i(dfr), .next_pc_i(npc), .sys_regs_i(sys),
      .instr_start_o(ist), .irq_cycle_o(irq), .global_irq_gate_o(gate), .req_flag_o(flg),
      .sp_o(sp), .isp_o(isp), .accepted_src_o(acc), .pc_load_o(pcl), .pc_load_valid_o(plv),
      .sys_out_o(sout), .sys_restore_valid_o(srv), .sys_clear_o(sclr));
   iasq_core_model core (.clk_i(clk), .rst_i(rst), .step_i(ist & ~irq), .load_i(plv),
      .load_pc_i(pcl), .next_pc_o(npc), .sys_regs_o(sys));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic next_instr();
      for (int i = 0; i < 500; i++) begin
         @(posedge clk);
         #1;
         if (ist === 1'b1) return;
      end
      n_errors++;
      $display("CHECK FAILED at %0t: no instruction start", $time);
      complete_run();
   endtask
   task automatic op(input logic e, input logic d, input logic r, input logic [NSRC-1:0] q);
      next_instr();
      {ein, dis, ret, rq} = {e, d, r, q};
      @(posedge clk);
      #1;
      {ein, dis, ret, rq} = '0;
   endtask
   initial begin
      {ein, dis, ret, dfr, rs, rq, swc, msk} = '0;
      rst = 1'b1;
      n_errors = 0;
      checks_done = 0;
      repeat (5) @(posedge clk);
      #1;
      rst = 1'b0;
      chk({gate, isp, sp}, {1'b0, ISP_EMPTY, SP_RST});
      msk = '1;
      op(1, 0, 0, 12'h008);
      next_instr();
      chk({gate, irq}, 2'b10);
      next_instr();
      rpc = npc;
      rsys = sys;
      chk({irq, gate, flg[3], sclr, plv}, 5'b10011);
      chk({pcl, sp, isp}, {14'h0009, 3'h7, 3'h4});
      chk(sout, sys & WIN_MASK);
      op(0, 0, 1, 12'h000);
      chk({plv, srv, pcl, sp}, {2'b11, rpc, 3'h0});
      chk({sout, isp}, {rsys, ISP_EMPTY});
      for (int i = 0; i < 3; i++) begin
         msk = (i == 0) ? 12'hffd : 12'hfff;
         op(1, 0, 0, (i == 0) ? 12'h026 : 12'h000);
         next_instr();
         next_instr();
         chk({acc, pcl}, {order[i], VEC_TOP - {10'h000, order[i]}});
         chk(flg[5], i < 2);
      end
      op(1, 0, 0, 12'h001);
      dfr = 1'b1;
      next_instr();
      next_instr();
      chk(irq, 0);
      dfr = 1'b0;
      next_instr();
      chk({irq, acc}, 5'h10);
      op(1, 0, 0, 12'h000);
      op(0, 1, 0, 12'h010);
      next_instr();
      chk({gate, irq, flg[4]}, 3'b001);
      msk = '0;
      for (int i = 0; i < 4; i++) begin
         op(1, 0, 0, 12'h000);
         next_instr();
         chk(gate, 1);
         rs[i] = 1'b1;
         @(posedge clk);
         #1;
         rs = '0;
         chk(gate, 0);
      end
      swc = 12'h010;
      @(posedge clk);
      #1;
      swc = '0;
      chk(flg, 0);
      complete_run();
   end
endmodule // iasq_sequencer_test
`default_nettype wire
